// ### verilog/dq_pkg.sv
// dq_pkg: register map, field positions, reset values and timing
// constants shared by the acquisition control block and its buffer.
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package dq_pkg;

	// register byte offsets
	localparam logic [7:0] DQ_CTRL_OFS = 8'h00;
	localparam logic [7:0] DQ_AICFG_OFS = 8'h04;
	localparam logic [7:0] DQ_COUNT_OFS = 8'h08;
	localparam logic [7:0] DQ_DATA_OFS = 8'h0C;
	localparam logic [7:0] DQ_STAT_OFS = 8'h10;
	localparam logic [7:0] DQ_AO0_OFS = 8'h14;
	localparam logic [7:0] DQ_AO1_OFS = 8'h18;
	localparam logic [7:0] DQ_DIR_OFS = 8'h1C;
	localparam logic [7:0] DQ_DOUT_OFS = 8'h20;
	localparam logic [7:0] DQ_DIN_OFS = 8'h24;
	localparam logic [7:0] DQ_EVCNT_OFS = 8'h28;
	localparam logic [7:0] DQ_PERIOD_OFS = 8'h2C;

	// control register bit positions (write-one pulses except DQ_CTRL_PIN_CNT)
	localparam int DQ_CTRL_START = 0;
	localparam int DQ_CTRL_STOP = 1;
	localparam int DQ_CTRL_CNT_START = 2;
	localparam int DQ_CTRL_PIN_CNT = 3;

	// acquisition config field positions
	localparam int DQ_CFG_CH_LSB = 0;   // bits 2:0 channel
	localparam int DQ_CFG_DIFF = 3;
	localparam int DQ_CFG_RANGE_LSB = 4; // bits 6:4 range code
	localparam int DQ_CFG_MODE_LSB = 8;  // bits 9:8 acquisition mode
	localparam int DQ_CFG_TRIG = 10;

	// acquisition modes
	localparam logic [1:0] DQ_MODE_SINGLE = 2'h0;
	localparam logic [1:0] DQ_MODE_FINITE = 2'h1;
	localparam logic [1:0] DQ_MODE_CONT = 2'h2;

	// sample buffer: 512 bytes of 16-bit samples
	localparam int DQ_BUF_AW = 8;
	localparam int DQ_BUF_DW = 16;

	// timebase figures: 24 MHz sample timebase, 10 MHz clock
	localparam int DQ_TB_HZ = 24000000;
	localparam int DQ_CLK_HZ = 10000000;
	localparam int DQ_TB_RES_PS = 41670;
	localparam int DQ_CLK_PS = 100000;
	// timebase ticks added per system clock (fixed-point accumulator)
	localparam logic [31:0] DQ_TB_STEP = 32'(DQ_TB_HZ / 1000);
	localparam logic [31:0] DQ_TB_WRAP = 32'(DQ_CLK_HZ / 1000);

	// reset values
	localparam logic [31:0] DQ_PERIOD_RST = 32'h00000960;
	localparam logic [11:0] DQ_DIR_RST = 12'h000;

	typedef enum logic [3:0] {
		DQ_IDLE = 4'b0001,
		DQ_ARM = 4'b0010,
		DQ_RUN = 4'b0100,
		DQ_CONV = 4'b1000
	} dq_state_t;

endpackage

// ### verilog/dq_fifo.sv
// dq_fifo: small synchronous sample buffer with registered read data.
// assumes one clock; writer must respect full, reader must respect empty.
`timescale 1ns/1ns
module dq_fifo
	import dq_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [DQ_BUF_DW-1:0] wr_data,
	// read side
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [DQ_BUF_DW-1:0] rd_data,
	// flush and fill level
	input wire logic flush,
	output logic [DQ_BUF_AW:0] level
);

	logic [DQ_BUF_DW-1:0] mem [0:(1<<DQ_BUF_AW)-1];
	logic [DQ_BUF_AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [DQ_BUF_DW-1:0] q_r;
	logic qv_r, qv_nxt;
	logic do_wr, do_pop, mem_has;

	assign level = wp_r - rp_r + {{DQ_BUF_AW{1'b0}}, qv_r};
	assign mem_has = (wp_r != rp_r);
	assign wr_ready = (wp_r - rp_r) != (DQ_BUF_AW+1)'(1 << DQ_BUF_AW);
	assign do_wr = wr_valid && wr_ready && !flush;
	assign rd_valid = qv_r;
	assign rd_data = q_r;
	// refill the output register whenever it is empty or being taken
	assign do_pop = mem_has && (!qv_r || rd_ready) && !flush;

	// pointer and output-valid next state
	always_comb begin
		wp_nxt = do_wr ? wp_r + 1'b1 : wp_r;
		rp_nxt = do_pop ? rp_r + 1'b1 : rp_r;
		qv_nxt = do_pop ? 1'b1 : (rd_ready ? 1'b0 : qv_r);
		if (flush) begin
			wp_nxt = '0;
			rp_nxt = '0;
			qv_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_r <= '0;
			rp_r <= '0;
			qv_r <= 1'b0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			qv_r <= qv_nxt;
		end
	end

	// storage and registered read data, no reset on the array
	always_ff @(posedge aclk) begin
		if (do_wr)
			mem[wp_r[DQ_BUF_AW-1:0]] <= wr_data;
		if (do_pop)
			q_r <= mem[rp_r[DQ_BUF_AW-1:0]];
	end

endmodule // dq_fifo

// ### verilog/dq_ctrl.sv
// dq_ctrl: acquisition sequencing, output converters, digital port,
// event counter and auxiliary power gate behind an AXI4-Lite slave.
// assumes converter samples arrive on the same clock; pins are async.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module dq_ctrl
	import dq_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter interface
	output logic [2:0] mux_pos_sel,
	output logic [2:0] mux_neg_sel,
	output logic diff_mode,
	output logic [4:0] gain_stage,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [15:0] conv_data,
	// output converter codes
	output logic [11:0] ao0_code,
	output logic [11:0] ao1_code,
	// digital port, open-drain: oe_n low pulls the line low
	input wire logic [7:0] wide_dio_group_i,
	output logic [7:0] wide_dio_group_o,
	output logic [7:0] wide_dio_group_oe_n,
	input wire logic [3:0] narrow_dio_group_i,
	output logic [3:0] narrow_dio_group_o,
	output logic [3:0] narrow_dio_group_oe_n,
	// shared trigger/counter pin and power gate
	input wire logic trigger_counter_pin,
	input wire logic usb_suspend,
	output logic aux_power_en
);

	// registers
	logic pin_cnt_r, pin_cnt_nxt;
	logic [10:0] cfg_r, cfg_nxt;
	logic [31:0] count_r, count_nxt, period_r, period_nxt;
	logic [31:0] left_r, left_nxt, evcnt_r, evcnt_nxt;
	logic [11:0] ao0_r, ao0_nxt, ao1_r, ao1_nxt, dir_r, dir_nxt;
	logic [11:0] dout_r, dout_nxt, din_r, din_nxt;
	logic ovr_r, ovr_nxt;
	dq_state_t st_r, st_nxt;
	logic [31:0] acc_r, acc_nxt, tick_r, tick_nxt;
	logic [2:0] tsync_r, ssync_r;
	logic [11:0] dsync1_r, dsync2_r;
	// bus state
	logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, b_r, b_nxt, r_r, r_nxt;
	logic [7:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic wr_go, rd_go;
	logic [31:0] rval;
	logic rok;
	// buffer wires
	logic f_ready, f_rvalid, f_pop, f_flush;
	logic [15:0] f_rdata;
	logic [DQ_BUF_AW:0] f_level;
	logic trig_rise, cnt_fall, tb_tick;
	logic [11:0] pin_in;

	// bus handshakes: each address channel held until the answer is taken
	assign s_axi_awready = !aw_h_r && !b_r;
	assign s_axi_wready = !w_h_r && !b_r;
	assign s_axi_arready = !r_r;
	assign s_axi_bvalid = b_r;
	assign s_axi_bresp = br_r;
	assign s_axi_rvalid = r_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r;
	// fire from registered holds and this edge's takes, never from next
	// state, so the write decision does not feed back on itself
	assign wr_go = (aw_h_r || (s_axi_awvalid && s_axi_awready)) &&
		(w_h_r || (s_axi_wvalid && s_axi_wready));
	assign rd_go = s_axi_arvalid && !r_r;

	dq_fifo u_buf (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_valid(conv_done && st_r == DQ_CONV),
		.wr_ready(f_ready),
		.wr_data(conv_data),
		.rd_valid(f_rvalid),
		.rd_ready(f_pop),
		.rd_data(f_rdata),
		.flush(f_flush),
		.level(f_level)
	);

	// trigger edge from two-stage synchroniser plus history bit
	assign trig_rise = !pin_cnt_r && tsync_r[1] && !tsync_r[2];
	// falling edge counted only in counter function
	assign cnt_fall = pin_cnt_r && !tsync_r[1] && tsync_r[2];
	assign pin_in = dsync2_r; // port lines after two flip-flops

	// read mux
	always_comb begin
		rval = 32'h00000000;
		rok = 1'b1;
		case (s_axi_araddr)
		DQ_CTRL_OFS: rval = {28'h0000000, pin_cnt_r, 3'h0};
		DQ_AICFG_OFS: rval = {21'h000000, cfg_r};
		DQ_COUNT_OFS: rval = count_r;
		DQ_DATA_OFS: rval = {15'h0000, f_rvalid, f_rdata};
		DQ_STAT_OFS: rval = {18'h00000, ovr_r, f_level, st_r};
		DQ_AO0_OFS: rval = {20'h00000, ao0_r};
		DQ_AO1_OFS: rval = {20'h00000, ao1_r};
		DQ_DIR_OFS: rval = {20'h00000, dir_r};
		DQ_DOUT_OFS: rval = {20'h00000, dout_r};
		DQ_DIN_OFS: rval = {20'h00000, din_r};
		DQ_EVCNT_OFS: rval = evcnt_r;
		DQ_PERIOD_OFS: rval = period_r;
		default: rok = 1'b0;
		endcase
	end

	// a data read pops one sample from the buffer
	assign f_pop = rd_go && s_axi_araddr == DQ_DATA_OFS;

	// fractional accumulator: 24 MHz ticks per 10 MHz clock
	// up to three ticks per clock; the count runs on through conversions
	// so spacing holds, and is preloaded while idle so a start converts
	always_comb begin
		acc_nxt = acc_r + DQ_TB_STEP;
		tick_nxt = tb_tick ? tick_r - period_r : tick_r;
		for (int k = 0; k < 3; k++) begin
			if (acc_nxt >= DQ_TB_WRAP) begin
				acc_nxt = acc_nxt - DQ_TB_WRAP;
				tick_nxt = tick_nxt + 32'h00000001;
			end
		end
		if (st_r == DQ_IDLE || st_r == DQ_ARM)
			tick_nxt = period_r;
	end
	assign tb_tick = st_r == DQ_RUN && tick_r >= period_r;

	// bus, register and sequencer next state
	always_comb begin
		aw_h_nxt = aw_h_r || s_axi_awvalid;
		w_h_nxt = w_h_r || s_axi_wvalid;
		awa_nxt = (s_axi_awvalid && !aw_h_r) ? s_axi_awaddr : awa_r;
		wd_nxt = (s_axi_wvalid && !w_h_r) ? s_axi_wdata : wd_r;
		b_nxt = b_r && !s_axi_bready;
		br_nxt = br_r;
		r_nxt = r_r && !s_axi_rready;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		pin_cnt_nxt = pin_cnt_r;
		cfg_nxt = cfg_r;
		count_nxt = count_r;
		period_nxt = period_r;
		ao0_nxt = ao0_r;
		ao1_nxt = ao1_r;
		dir_nxt = dir_r;
		dout_nxt = dout_r;
		din_nxt = din_r;
		evcnt_nxt = evcnt_r;
		left_nxt = left_r;
		ovr_nxt = ovr_r;
		st_nxt = st_r;
		f_flush = 1'b0;
		if (b_r) begin
			aw_h_nxt = aw_h_r;
			w_h_nxt = w_h_r;
		end
		// falling edge counts, wraps naturally at 32 bits
		if (cnt_fall)
			evcnt_nxt = evcnt_r + 32'h00000001;
		// acquisition sequencing
		case (st_r)
		DQ_IDLE: ;
		// wait for rising edge, one edge per arming
		DQ_ARM: if (trig_rise) st_nxt = DQ_RUN;
		DQ_RUN: if (tb_tick) st_nxt = DQ_CONV;
		DQ_CONV: begin
			if (conv_done) begin
				if (!f_ready)
					ovr_nxt = 1'b1;
				if (cfg_r[DQ_CFG_MODE_LSB +: 2] == DQ_MODE_SINGLE ||
				    (cfg_r[DQ_CFG_MODE_LSB +: 2] == DQ_MODE_FINITE &&
				    left_r <= 32'h00000001))
					st_nxt = DQ_IDLE;
				else
					st_nxt = DQ_RUN;
				left_nxt = left_r - 32'h00000001;
			end
		end
		default: st_nxt = DQ_IDLE;
		endcase
		if (wr_go) begin
			aw_h_nxt = 1'b0;
			w_h_nxt = 1'b0;
			b_nxt = 1'b1;
			br_nxt = 2'b00;
			if (s_axi_wstrb != 4'h0 || 1'b1)
			case (awa_nxt)
			DQ_CTRL_OFS: begin
				// pin function chosen in one bit
				pin_cnt_nxt = wd_nxt[DQ_CTRL_PIN_CNT];
				if (wd_nxt[DQ_CTRL_START]) begin
					f_flush = 1'b1;
					ovr_nxt = 1'b0;
					left_nxt = count_r;
					st_nxt = (cfg_r[DQ_CFG_TRIG] &&
						!wd_nxt[DQ_CTRL_PIN_CNT]) ? DQ_ARM : DQ_RUN;
				end
				if (wd_nxt[DQ_CTRL_STOP])
					st_nxt = DQ_IDLE;
				if (wd_nxt[DQ_CTRL_CNT_START])
					evcnt_nxt = 32'h00000000;
			end
			DQ_AICFG_OFS: cfg_nxt = wd_nxt[10:0];
			DQ_COUNT_OFS: count_nxt = wd_nxt;
			DQ_PERIOD_OFS: period_nxt = wd_nxt;
			DQ_AO0_OFS: ao0_nxt = wd_nxt[11:0];
			DQ_AO1_OFS: ao1_nxt = wd_nxt[11:0];
			DQ_DIR_OFS: dir_nxt = wd_nxt[11:0];
			DQ_DOUT_OFS: dout_nxt = wd_nxt[11:0];
			default: br_nxt = 2'b10;
			endcase
		end
		if (rd_go) begin
			r_nxt = 1'b1;
			rd_nxt = rval;
			rr_nxt = rok ? 2'b00 : 2'b10;
			// port sampled on each software read of DQ_DIN_OFS
			if (s_axi_araddr == DQ_DIN_OFS) begin
				din_nxt = pin_in;
				rd_nxt = {20'h00000, pin_in};
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h_r <= 1'b0;
			w_h_r <= 1'b0;
			awa_r <= 8'h00;
			wd_r <= 32'h00000000;
			b_r <= 1'b0;
			br_r <= 2'b00;
			r_r <= 1'b0;
			rd_r <= 32'h00000000;
			rr_r <= 2'b00;
			pin_cnt_r <= 1'b0;
			cfg_r <= 11'h000;
			count_r <= 32'h00000000;
			period_r <= DQ_PERIOD_RST;
			ao0_r <= 12'h000;
			ao1_r <= 12'h000;
			// all lines undriven inputs after reset
			dir_r <= DQ_DIR_RST;
			dout_r <= 12'h000;
			din_r <= 12'h000;
			evcnt_r <= 32'h00000000;
			left_r <= 32'h00000000;
			ovr_r <= 1'b0;
			st_r <= DQ_IDLE;
			acc_r <= 32'h00000000;
			tick_r <= 32'h00000000;
			tsync_r <= 3'h0;
			ssync_r <= 3'h0;
			dsync1_r <= 12'h000;
			dsync2_r <= 12'h000;
		end else begin
			aw_h_r <= aw_h_nxt;
			w_h_r <= w_h_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			b_r <= b_nxt;
			br_r <= br_nxt;
			r_r <= r_nxt;
			rd_r <= rd_nxt;
			rr_r <= rr_nxt;
			pin_cnt_r <= pin_cnt_nxt;
			cfg_r <= cfg_nxt;
			count_r <= count_nxt;
			period_r <= period_nxt;
			ao0_r <= ao0_nxt;
			ao1_r <= ao1_nxt;
			dir_r <= dir_nxt;
			dout_r <= dout_nxt;
			din_r <= din_nxt;
			evcnt_r <= evcnt_nxt;
			left_r <= left_nxt;
			ovr_r <= ovr_nxt;
			st_r <= st_nxt;
			acc_r <= acc_nxt;
			tick_r <= tick_nxt;
			tsync_r <= {tsync_r[1:0], trigger_counter_pin};
			ssync_r <= {ssync_r[1:0], usb_suspend};
			dsync1_r <= {narrow_dio_group_i, wide_dio_group_i};
			dsync2_r <= dsync1_r;
		end
	end

	// one channel routed; differential pairs n and n+4
	assign mux_pos_sel = cfg_r[DQ_CFG_DIFF] ?
		{1'b0, cfg_r[DQ_CFG_CH_LSB +: 2]} : cfg_r[DQ_CFG_CH_LSB +: 3];
	assign mux_neg_sel = {1'b1, cfg_r[DQ_CFG_CH_LSB +: 2]};
	assign diff_mode = cfg_r[DQ_CFG_DIFF];
	assign conv_start = st_r == DQ_RUN && tb_tick;

	// differential gain from range code: 20,10,5,4,2.5,2,1.25,1 volts; single-ended gain is 1
	always_comb begin
		gain_stage = 5'h01;
		if (cfg_r[DQ_CFG_DIFF]) begin
			case (cfg_r[DQ_CFG_RANGE_LSB +: 3])
			3'h0: gain_stage = 5'h01;
			3'h1: gain_stage = 5'h02;
			3'h2: gain_stage = 5'h04;
			3'h3: gain_stage = 5'h05;
			3'h4: gain_stage = 5'h08;
			3'h5: gain_stage = 5'h0A;
			3'h6: gain_stage = 5'h10;
			default: gain_stage = 5'h14;
			endcase
		end
	end

	assign ao0_code = ao0_r;
	assign ao1_code = ao1_r;
	// open-drain: drive low only for output lines holding 0
	assign wide_dio_group_o = 8'h00;
	assign narrow_dio_group_o = 4'h0;
	assign wide_dio_group_oe_n = ~(dir_r[7:0] & ~dout_r[7:0]);
	assign narrow_dio_group_oe_n = ~(dir_r[11:8] & ~dout_r[11:8]);
	assign aux_power_en = aresetn && !ssync_r[1];

endmodule // dq_ctrl

// ### dv/dq_adc_model.sv
// dq_adc_model: behavioural converter answering each conversion start.
// assumes conv_start is a one-cycle pulse on aclk; samples count up.
`timescale 1ns/1ns
module dq_adc_model #(
	parameter int LAT = 3
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converter handshake
	input wire logic conv_start,
	output logic conv_done,
	output logic [15:0] conv_data
);
	int cnt;
	logic [15:0] smp;

	// latency counter; data bus scrambles outside the done pulse
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 0;
			smp <= 16'h1000;
			conv_done <= 1'b0;
			conv_data <= 16'h5A5A;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data; // stale value never looks valid
			if (conv_start)
				cnt <= LAT;
			else if (cnt == 1) begin
				conv_done <= 1'b1;
				conv_data <= smp;
				smp <= smp + 16'h0001;
				cnt <= 0;
			end else if (cnt > 1)
				cnt <= cnt - 1;
		end
	end
endmodule // dq_adc_model

// ### dv/dq_ctrl_properties.sv
// dq_ctrl_properties: port-level checks on the acquisition control block.
// assumes it is bound onto dq_ctrl and sees only its ports.
`timescale 1ns/1ns
module dq_ctrl_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus write data valid
	input wire logic s_axi_wvalid,
	// converter side
	input wire logic [2:0] mux_pos_sel,
	input wire logic [2:0] mux_neg_sel,
	input wire logic diff_mode,
	input wire logic [4:0] gain_stage,
	input wire logic conv_start,
	// outputs and pins
	input wire logic [11:0] ao0_code,
	input wire logic [11:0] ao1_code,
	input wire logic [7:0] wide_dio_group_o,
	input wire logic [7:0] wide_dio_group_oe_n,
	input wire logic [3:0] narrow_dio_group_o,
	input wire logic [3:0] narrow_dio_group_oe_n,
	input wire logic usb_suspend,
	input wire logic aux_power_en
);
	// single domain, so clock and reset are stated once
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_one_conv: assert property (conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	a_se_gain: assert property (!diff_mode |-> gain_stage == 5'h01)
		else $error("single-ended gain not one");
	a_diff_gain: assert property (diff_mode |-> gain_stage inside
		{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h10, 5'h14})
		else $error("differential gain not legal");
	a_diff_pair: assert property (diff_mode |->
		!mux_pos_sel[2] && mux_neg_sel == {1'b1, mux_pos_sel[1:0]})
		else $error("differential legs not paired");
	a_ao_sw_only: assert property ($changed({ao1_code, ao0_code}) |->
		$past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
		else $error("output code moved without a write");
	a_dio_sw_only: assert property ($changed({narrow_dio_group_oe_n,
		wide_dio_group_oe_n}) |-> $past(s_axi_wvalid) ||
		$past(s_axi_wvalid, 2))
		else $error("port drive moved without a write");
	a_open_drain: assert property (
		wide_dio_group_o == 8'h00 && narrow_dio_group_o == 4'h0)
		else $error("port drives high");
	a_dio_reset: assert property (aresetn && !$past(aresetn) |->
		&{narrow_dio_group_oe_n, wide_dio_group_oe_n})
		else $error("port driven after reset");
	a_aux_off: assert property (usb_suspend [*4] |-> !aux_power_en)
		else $error("aux power on in suspend");
	a_aux_on: assert property (!usb_suspend [*4] |-> aux_power_en)
		else $error("aux power off outside suspend");
endmodule // dq_ctrl_properties

bind dq_ctrl dq_ctrl_properties u_props (.aclk, .aresetn, .s_axi_wvalid,
	.mux_pos_sel, .mux_neg_sel, .diff_mode, .gain_stage, .conv_start,
	.ao0_code, .ao1_code, .wide_dio_group_o, .wide_dio_group_oe_n,
	.narrow_dio_group_o, .narrow_dio_group_oe_n, .usb_suspend,
	.aux_power_en);

// ### dv/daq_io_control_test.sv
// daq_io_control_test: register-level tests of the acquisition block.
// assumes dq_ctrl with a behavioural converter and pulled-up port lines.
`timescale 1ns/1ns
module daq_io_control_test;
	import dq_pkg::*;
	localparam logic [31:0] GAINS [8] = '{1, 2, 4, 5, 8, 10, 16, 20};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic trigger_counter_pin = 1'b0, usb_suspend = 1'b0;
	logic [11:0] ext_n = 12'hFFF; // low bit: external load pulls line low
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, diff_mode, conv_start, conv_done, aux_power_en;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd_v;
	logic [2:0] mux_pos_sel, mux_neg_sel;
	logic [4:0] gain_stage;
	logic [15:0] conv_data;
	logic [11:0] ao0_code, ao1_code;
	logic [7:0] wide_dio_group_o, wide_dio_group_oe_n;
	logic [3:0] narrow_dio_group_o, narrow_dio_group_oe_n;
	int err_total = 0;
	int samples_checked = 0;

	always #50 aclk = ~aclk;

	// port lines resolve open drain against the pull-ups
	dq_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mux_pos_sel,
		.mux_neg_sel, .diff_mode, .gain_stage, .conv_start, .conv_done,
		.conv_data, .ao0_code, .ao1_code,
		.wide_dio_group_i(wide_dio_group_oe_n & ext_n[7:0]),
		.wide_dio_group_o, .wide_dio_group_oe_n,
		.narrow_dio_group_i(narrow_dio_group_oe_n & ext_n[11:8]),
		.narrow_dio_group_o, .narrow_dio_group_oe_n,
		.trigger_counter_pin, .usb_suspend, .aux_power_en);
	dq_adc_model #(.LAT(3)) u_adc (.aclk, .aresetn, .conv_start,
		.conv_done, .conv_data);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a);
		bit done;
		done = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd_v = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1;
			end
		end
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#2000000;
		err_total++;
		conclude;
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(DQ_PERIOD_OFS);
		chk(rd_v, 32'h960);
		rd(DQ_DIR_OFS);
		chk(rd_v, 32'h0);
		chk(32'({narrow_dio_group_oe_n, wide_dio_group_oe_n}), 32'hFFF);
		rd(DQ_STAT_OFS);
		chk(rd_v, 32'h1);
		chk(32'(aux_power_en), 32'h1);
		rd(8'h40);
		chk(32'(resp), 32'h2);
		wr(8'h40, 32'h1);
		chk(32'(resp), 32'h2);
		wr(DQ_AO0_OFS, 32'hABC);
		wr(DQ_AO1_OFS, 32'h123);
		chk(32'({ao1_code, ao0_code}), 32'h123ABC);
		wr(DQ_DIR_OFS, 32'hA5C);
		wr(DQ_DOUT_OFS, 32'h0F0);
		chk(32'({narrow_dio_group_oe_n, wide_dio_group_oe_n}), 32'h5F3);
		ext_n <= 12'hF0F;
		repeat (4) @(posedge aclk);
		rd(DQ_DIN_OFS);
		chk(rd_v, 32'h503);
		for (int r = 0; r < 8; r++) begin
			wr(DQ_AICFG_OFS, 32'hA | (32'(r) << 4));
			chk(32'(gain_stage), GAINS[r]);
			chk(32'({diff_mode, mux_neg_sel, mux_pos_sel}), 32'h72);
		end
		wr(DQ_AICFG_OFS, 32'h72);
		chk(32'({diff_mode, gain_stage}), 32'h1);
		// finite run held back until the pin rises
		wr(DQ_PERIOD_OFS, 32'h30);
		wr(DQ_COUNT_OFS, 32'h3);
		wr(DQ_AICFG_OFS, 32'h502);
		wr(DQ_CTRL_OFS, 32'h1);
		repeat (40) @(posedge aclk);
		rd(DQ_STAT_OFS);
		chk(rd_v, 32'h2);
		trigger_counter_pin <= 1'b1;
		for (int i = 0; i < 50 && rd_v[3:0] !== 4'h1; i++)
			rd(DQ_STAT_OFS);
		chk(rd_v, 32'h31);
		for (int i = 0; i < 3; i++) begin
			rd(DQ_DATA_OFS);
			chk(rd_v, 32'(32'h11000 + i));
		end
		rd(DQ_DATA_OFS);
		chk(32'(rd_v[16]), 32'h0);
		// a second edge must not start another run
		trigger_counter_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		trigger_counter_pin <= 1'b1;
		repeat (60) @(posedge aclk);
		rd(DQ_STAT_OFS);
		chk(rd_v, 32'h1);
		// single conversion, then a continuous run past the count
		wr(DQ_AICFG_OFS, 32'h002);
		wr(DQ_CTRL_OFS, 32'h1);
		repeat (20) @(posedge aclk);
		rd(DQ_DATA_OFS);
		chk(rd_v, 32'h11003);
		rd(DQ_STAT_OFS);
		chk(rd_v, 32'h1);
		wr(DQ_AICFG_OFS, 32'h202);
		wr(DQ_CTRL_OFS, 32'h1);
		for (int i = 0; i < 100 && rd_v[12:4] < 9'h004; i++)
			rd(DQ_STAT_OFS);
		chk(32'(rd_v[3:0] != 4'h1), 32'h1);
		chk(32'(rd_v[12:4] >= 9'h004), 32'h1);
		wr(DQ_CTRL_OFS, 32'h2);
		rd(DQ_STAT_OFS);
		chk(32'(rd_v[3:0]), 32'h1);
		// counting mode, five falling edges
		wr(DQ_CTRL_OFS, 32'hC);
		for (int i = 0; i < 10; i++) begin
			repeat (4) @(posedge aclk);
			trigger_counter_pin <= ~trigger_counter_pin;
		end
		repeat (4) @(posedge aclk);
		rd(DQ_EVCNT_OFS);
		chk(rd_v, 32'h5);
		wr(DQ_CTRL_OFS, 32'hC);
		rd(DQ_EVCNT_OFS);
		chk(rd_v, 32'h0);
		usb_suspend <= 1'b1;
		repeat (5) @(posedge aclk);
		chk(32'(aux_power_en), 32'h0);
		usb_suspend <= 1'b0;
		repeat (5) @(posedge aclk);
		chk(32'(aux_power_en), 32'h1);
		conclude;
	end
endmodule // daq_io_control_test
